/* core/cdd_decoder.sv */
// Behaviour
// R1 - Only command latch and data latch reachable
// R2 - While busy, only status read accepted
// R3 - Busy high while a command executes
// R4 - Host polls busy before next command
// R5 - Clear blanks display, pointer to zero
// R6 - Home zeroes pointer and shift, keeps RAM
// R7 - Entry mode latches step and glide
// R8 - Data access steps pointer by one
// R9 - Pointer update shows after busy ends
// R10 - Display control latches three enables
// R11 - Shift moves cursor or display, RAM intact
// R12 - Same group sets graphic and power
// R13 - Function set latches four fields together
// R14 - Glyph address loads pointer, selects glyph RAM
// R15 - Display address loads pointer, selects display RAM
// R16 - Status read gives busy and pointer
// R17 - Data write goes to selected RAM
// R18 - Data read returns byte at pointer
// R19 - Glide shifts display with data access
// R20 - Host port: 8080, 6800 or serial
// R21 - Low bits 11 mode, 00 shift
// R22 - Eight lines, or upper four twice
// R23 - Clear fills 20H and sets step up
// R24 - Row count and glyph height selections
// R25 - Four-bit: upper nibble first, then execute
// R26 - Highest set bit picks command group
`timescale 1ns/1ps
`default_nettype none

module cdd_decoder #(
	parameter int unsigned CLEAR_CYC = cdd_pkg::CLEAR_CYC_DFLT,
	parameter int unsigned CMD_CYC = cdd_pkg::CMD_CYC_DFLT
) (
	input wire logic core_clk_i, // Core clock
	input wire logic rst_b_i, // Async reset, active low
	input wire cdd_pkg::cdd_bus_mode_t bus_mode_i, // Host bus style
	input wire logic chip_select_n_i, // Chip select, active low
	input wire logic register_select_i, // 0 command, 1 data
	input wire logic strobe_read_i, // Read strobe or E
	input wire logic rw_strobe_write_i, // Write strobe or R/W
	input wire logic [7:0] db_i, // Data pins in
	output logic [7:0] db_o, // Data pins out
	output logic [7:0] db_oe_o, // Data pin drive enables
	output logic busy_indicator_o, // Command executing
	output logic [6:0] cursor_pointer_o, // RAM address counter
	output logic [6:0] display_offset_o, // Display shift amount
	output logic sel_display_ram_o, // 1 display RAM selected
	output cdd_pkg::cdd_cfg_t cfg_o, // Latched settings
	input wire logic [6:0] display_view_addr_i, // Renderer address
	output logic [7:0] display_view_o, // Renderer char code
	input wire logic [5:0] glyph_view_addr_i, // Renderer address
	output logic [7:0] glyph_view_o // Renderer glyph row
);
	import cdd_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_CLEAR} cdd_state_t;

	// ------------------------------------------------------------------
	// Pin synchroniser
	// ------------------------------------------------------------------
	cdd_pins_t pin_now;
	cdd_pins_t s1_r;
	cdd_pins_t s2_r;
	cdd_pins_t s3_r;

	assign pin_now = '{mode: bus_mode_i, cs_n: chip_select_n_i,
		rs: register_select_i, rd: strobe_read_i,
		wr: rw_strobe_write_i, db: db_i};

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s1_r <= '{mode: 2'h0, cs_n: 1'b1, rs: 1'b0, rd: 1'b1,
				wr: 1'b1, db: 8'h00};
			s2_r <= '{mode: 2'h0, cs_n: 1'b1, rs: 1'b0, rd: 1'b1,
				wr: 1'b1, db: 8'h00};
			s3_r <= '{mode: 2'h0, cs_n: 1'b1, rs: 1'b0, rd: 1'b1,
				wr: 1'b1, db: 8'h00};
		end else begin
			s1_r <= pin_now;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	cdd_state_t state_r, state_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic [6:0] clr_addr_r, clr_addr_nxt;
	logic [6:0] ptr_r, ptr_nxt;
	logic [6:0] ofs_r, ofs_nxt;
	logic sel_dd_r, sel_dd_nxt;
	cdd_cfg_t cfg_r, cfg_nxt;
	logic pend_ptr_r, pend_ptr_nxt;
	logic pend_ofs_r, pend_ofs_nxt;
	logic ptr_up_r, ptr_up_nxt;
	logic ofs_up_r, ofs_up_nxt;
	logic nib_r, nib_nxt;
	logic [3:0] hold_r, hold_nxt;
	logic [3:0] ser_cnt_r, ser_cnt_nxt;
	logic [8:0] ser_in_r, ser_in_nxt;
	logic [7:0] ser_out_r, ser_out_nxt;
	logic [7:0] db_r, db_nxt;
	logic [7:0] oe_r, oe_nxt;
	logic [7:0] dview_r, dview_nxt;
	logic [7:0] gview_r, gview_nxt;

	logic [7:0] dd_mem [DD_DEPTH];
	logic [7:0] cg_mem [CG_DEPTH];
	logic mem_we;
	logic mem_dd;
	logic [6:0] mem_addr;
	logic [7:0] mem_wdata;

	logic [7:0] status_val;
	logic [7:0] data_val;
	logic [7:0] rd_val;
	logic busy;
	logic par_end;
	logic par_rnw;
	logic par_reading;
	logic go;
	logic g_rs;
	logic g_rnw;
	logic [7:0] g_byte;

	assign busy = (state_r != ST_IDLE);
	assign status_val = {busy, ptr_r}; // R16
	assign data_val = sel_dd_r ? dd_mem[ptr_r] : cg_mem[ptr_r[5:0]]; // R18

	// ------------------------------------------------------------------
	// Host port decode
	// ------------------------------------------------------------------
	always_comb begin
		par_end = 1'b0;
		par_rnw = 1'b0;
		par_reading = 1'b0;
		case (cdd_bus_mode_t'(s2_r.mode))
			BM_8080: begin
				par_end = ~s3_r.cs_n & ((s2_r.rd & ~s3_r.rd) |
					(s2_r.wr & ~s3_r.wr)); // R20
				par_rnw = s2_r.rd & ~s3_r.rd;
				par_reading = ~s2_r.cs_n & ~s2_r.rd;
			end
			BM_6800: begin
				par_end = ~s3_r.cs_n & ~s2_r.rd & s3_r.rd; // R20
				par_rnw = s3_r.wr;
				par_reading = ~s2_r.cs_n & s2_r.rd & s2_r.wr;
			end
			default: begin
			end
		endcase
	end

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		clr_addr_nxt = clr_addr_r;
		ptr_nxt = ptr_r;
		ofs_nxt = ofs_r;
		sel_dd_nxt = sel_dd_r;
		cfg_nxt = cfg_r;
		pend_ptr_nxt = pend_ptr_r;
		pend_ofs_nxt = pend_ofs_r;
		ptr_up_nxt = ptr_up_r;
		ofs_up_nxt = ofs_up_r;
		nib_nxt = nib_r;
		hold_nxt = hold_r;
		ser_cnt_nxt = ser_cnt_r;
		ser_in_nxt = ser_in_r;
		ser_out_nxt = ser_out_r;
		mem_we = 1'b0;
		mem_dd = 1'b1;
		mem_addr = ptr_r;
		mem_wdata = s3_r.db;
		go = 1'b0;
		g_rs = s3_r.rs;
		g_rnw = par_rnw;
		g_byte = s3_r.db;
		rd_val = s2_r.rs ? data_val : status_val; // R1

		// Parallel transfers, one or two strobes per byte
		if (par_end) begin
			if (cfg_r.bus_width_8) begin
				go = 1'b1; // R22
			end else if (!nib_r) begin
				hold_nxt = s3_r.db[7:4]; // R25
				nib_nxt = 1'b1;
			end else begin
				go = 1'b1; // R25
				g_byte = {hold_r, s3_r.db[7:4]}; // R22
				nib_nxt = 1'b0;
			end
		end

		// Serial frame: select, direction, then eight bits msb first
		if (cdd_bus_mode_t'(s2_r.mode) == BM_SERIAL) begin
			if (s2_r.cs_n) begin
				ser_cnt_nxt = 4'h0;
			end else if (s2_r.db[SCL_POS] & ~s3_r.db[SCL_POS]) begin
				ser_in_nxt = {ser_in_r[7:0], s2_r.db[SDI_POS]}; // R20
				ser_cnt_nxt = ser_cnt_r + 4'h1;
				if (ser_cnt_r == SER_LOAD_BIT) begin
					ser_out_nxt = ser_in_r[0] ? data_val : status_val;
				end else if (ser_cnt_r > SER_LOAD_BIT) begin
					ser_out_nxt = {ser_out_r[6:0], 1'b0};
				end
				if (ser_cnt_r == SER_LAST_BIT) begin
					go = 1'b1;
					g_rs = ser_in_r[8];
					g_rnw = ser_in_r[7];
					g_byte = {ser_in_r[6:0], s2_r.db[SDI_POS]};
					ser_cnt_nxt = 4'h0;
				end
			end
		end

		// Execution timer; pointer steps only as busy drops
		case (state_r)
			ST_IDLE: begin
			end
			ST_EXEC: begin
				if (cnt_r == '0) begin
					state_nxt = ST_IDLE; // R3
					if (pend_ptr_r) begin
						ptr_nxt = ptr_r + (ptr_up_r ? STEP_PLUS
							: STEP_MINUS); // R9
						if (!sel_dd_r) begin
							ptr_nxt = ptr_nxt & CG_ADDR_MASK;
						end
					end
					if (pend_ofs_r) begin
						ofs_nxt = ofs_r + (ofs_up_r ? STEP_PLUS
							: STEP_MINUS); // R19
					end
					pend_ptr_nxt = 1'b0;
					pend_ofs_nxt = 1'b0;
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			ST_CLEAR: begin
				mem_we = 1'b1;
				mem_dd = 1'b1;
				mem_addr = clr_addr_r;
				mem_wdata = BLANK_CODE; // R23
				clr_addr_nxt = clr_addr_r + STEP_PLUS;
				if (cnt_r == '0) begin
					state_nxt = ST_IDLE; // R3
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase

		// Accepted host access; status read is always allowed
		if (go && !(busy && !(!g_rs && g_rnw))) begin // R2
			if (g_rnw) begin
				if (g_rs) begin
					pend_ptr_nxt = 1'b1; // R8
					ptr_up_nxt = cfg_r.step_up; // R7
					pend_ofs_nxt = sel_dd_r & cfg_r.window_glide_on_entry;
					ofs_up_nxt = ~cfg_r.step_up;
					state_nxt = ST_EXEC;
					cnt_nxt = CNT_W'(CMD_CYC - 1);
				end
			end else if (g_rs) begin
				mem_we = 1'b1; // R17
				mem_dd = sel_dd_r;
				mem_addr = ptr_r;
				mem_wdata = g_byte;
				pend_ptr_nxt = 1'b1; // R8
				ptr_up_nxt = cfg_r.step_up; // R7
				pend_ofs_nxt = sel_dd_r & cfg_r.window_glide_on_entry; // R19
				ofs_up_nxt = ~cfg_r.step_up;
				state_nxt = ST_EXEC;
				cnt_nxt = CNT_W'(CMD_CYC - 1);
			end else begin
				state_nxt = ST_EXEC; // R3
				cnt_nxt = CNT_W'(CMD_CYC - 1);
				casez (g_byte) // R26
					8'b1???????: begin
						ptr_nxt = g_byte[6:0]; // R15
						sel_dd_nxt = 1'b1;
					end
					8'b01??????: begin
						ptr_nxt = {1'b0, g_byte[5:0]}; // R14
						sel_dd_nxt = 1'b0;
					end
					8'b001?????: begin
						cfg_nxt.bus_width_8 = g_byte[FS_BW8_POS]; // R13
						cfg_nxt.two_row = g_byte[FS_ROW_POS]; // R24
						cfg_nxt.glyph_height = g_byte[FS_HGT_POS];
						cfg_nxt.font_table_select = g_byte[1:0];
					end
					8'b0001????: begin
						if (g_byte[1:0] == SH_SUB_MODE) begin // R21
							cfg_nxt.graphic_select = g_byte[SH_TGT_POS]; // R12
							cfg_nxt.dcdc_enable = g_byte[SH_DIR_POS];
						end else if (g_byte[1:0] == SH_SUB_CURSOR) begin
							if (g_byte[SH_TGT_POS]) begin
								pend_ofs_nxt = 1'b1; // R11
								ofs_up_nxt = g_byte[SH_DIR_POS];
							end else begin
								pend_ptr_nxt = 1'b1; // R11
								ptr_up_nxt = g_byte[SH_DIR_POS];
							end
						end
					end
					8'b00001???: begin
						cfg_nxt.screen_on = g_byte[2]; // R10
						cfg_nxt.pointer_mark_shown = g_byte[1];
						cfg_nxt.flashing_on = g_byte[0];
					end
					8'b000001??: begin
						cfg_nxt.step_up = g_byte[1]; // R7
						cfg_nxt.window_glide_on_entry = g_byte[0];
					end
					8'b0000001?: begin
						ptr_nxt = HOME_ADDR; // R6
						ofs_nxt = HOME_ADDR;
						sel_dd_nxt = 1'b1;
					end
					8'b00000001: begin
						ptr_nxt = HOME_ADDR; // R5
						ofs_nxt = HOME_ADDR;
						sel_dd_nxt = 1'b1;
						cfg_nxt.step_up = 1'b1; // R23
						pend_ptr_nxt = 1'b0;
						pend_ofs_nxt = 1'b0;
						clr_addr_nxt = HOME_ADDR;
						state_nxt = ST_CLEAR;
						cnt_nxt = CNT_W'(CLEAR_CYC - 1);
					end
					default: begin
						state_nxt = ST_IDLE;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// Data pin drive
	// ------------------------------------------------------------------
	always_comb begin
		db_nxt = 8'h00;
		oe_nxt = 8'h00;
		if (cdd_bus_mode_t'(s2_r.mode) == BM_SERIAL) begin
			if (!s2_r.cs_n && ser_cnt_r > SER_LOAD_BIT) begin
				db_nxt[SDO_POS] = ser_out_r[7];
				oe_nxt[SDO_POS] = 1'b1;
			end
		end else if (par_reading) begin
			if (cfg_r.bus_width_8) begin
				db_nxt = rd_val; // R22
				oe_nxt = 8'hFF;
			end else begin
				db_nxt[7:4] = nib_r ? rd_val[3:0] : rd_val[7:4]; // R25
				oe_nxt = 8'hF0;
			end
		end
		dview_nxt = dd_mem[display_view_addr_i];
		gview_nxt = cg_mem[glyph_view_addr_i];
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_r <= ST_IDLE;
			cnt_r <= '0;
			clr_addr_r <= HOME_ADDR;
			ptr_r <= HOME_ADDR;
			ofs_r <= HOME_ADDR;
			sel_dd_r <= RST_SEL_DD;
			cfg_r <= '{step_up: RST_STEP_UP, bus_width_8: RST_BUS_WIDTH_8,
				default: '0};
			pend_ptr_r <= 1'b0;
			pend_ofs_r <= 1'b0;
			ptr_up_r <= 1'b1;
			ofs_up_r <= 1'b0;
			nib_r <= 1'b0;
			hold_r <= 4'h0;
			ser_cnt_r <= 4'h0;
			ser_in_r <= 9'h000;
			ser_out_r <= 8'h00;
			db_r <= 8'h00;
			oe_r <= 8'h00;
			dview_r <= 8'h00;
			gview_r <= 8'h00;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			clr_addr_r <= clr_addr_nxt;
			ptr_r <= ptr_nxt;
			ofs_r <= ofs_nxt;
			sel_dd_r <= sel_dd_nxt;
			cfg_r <= cfg_nxt;
			pend_ptr_r <= pend_ptr_nxt;
			pend_ofs_r <= pend_ofs_nxt;
			ptr_up_r <= ptr_up_nxt;
			ofs_up_r <= ofs_up_nxt;
			nib_r <= nib_nxt;
			hold_r <= hold_nxt;
			ser_cnt_r <= ser_cnt_nxt;
			ser_in_r <= ser_in_nxt;
			ser_out_r <= ser_out_nxt;
			db_r <= db_nxt;
			oe_r <= oe_nxt;
			dview_r <= dview_nxt;
			gview_r <= gview_nxt;
		end
	end

	// RAM contents are not reset; clear fills the display RAM
	always_ff @(posedge core_clk_i) begin
		if (mem_we) begin
			if (mem_dd) begin
				dd_mem[mem_addr] <= mem_wdata;
			end else begin
				cg_mem[mem_addr[5:0]] <= mem_wdata;
			end
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign db_o = db_r;
	assign db_oe_o = oe_r;
	assign busy_indicator_o = busy; // R3
	assign cursor_pointer_o = ptr_r;
	assign display_offset_o = ofs_r;
	assign sel_display_ram_o = sel_dd_r;
	assign cfg_o = cfg_r;
	assign display_view_o = dview_r;
	assign glyph_view_o = gview_r;

endmodule // cdd_decoder

`default_nettype wire

/* core/cdd_pkg.sv */
package cdd_pkg;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned CLEAR_TIME_NS = 6200000;
	// Longest time: rounded down to whole cycles
	localparam int unsigned CLEAR_CYC_DFLT = CLEAR_TIME_NS / CLK_PERIOD_NS;
	// Ordinary command time is not given; plain default
	localparam int unsigned CMD_TIME_NS = 600;
	localparam int unsigned CMD_CYC_DFLT = CMD_TIME_NS / CLK_PERIOD_NS;
	localparam int CNT_W = 24;

	// ------------------------------------------------------------------
	// Memories and constants
	// ------------------------------------------------------------------
	localparam int unsigned DD_DEPTH = 128;
	localparam int unsigned CG_DEPTH = 64;
	localparam logic [7:0] BLANK_CODE = 8'h20;
	localparam logic [6:0] HOME_ADDR = 7'h00;
	localparam logic [6:0] STEP_PLUS = 7'h01;
	localparam logic [6:0] STEP_MINUS = 7'h7F;
	localparam logic [6:0] CG_ADDR_MASK = 7'h3F;
	localparam logic [3:0] SER_LOAD_BIT = 4'h1;
	localparam logic [3:0] SER_LAST_BIT = 4'h9;
	localparam int SCL_POS = 5;
	localparam int SDO_POS = 6;
	localparam int SDI_POS = 7;

	// ------------------------------------------------------------------
	// Command field positions
	// ------------------------------------------------------------------
	localparam int FS_BW8_POS = 4;
	localparam int FS_ROW_POS = 3;
	localparam int FS_HGT_POS = 2;
	localparam int SH_TGT_POS = 3;
	localparam int SH_DIR_POS = 2;
	localparam logic [1:0] SH_SUB_CURSOR = 2'h0;
	localparam logic [1:0] SH_SUB_MODE = 2'h3;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic RST_BUS_WIDTH_8 = 1'b1;
	localparam logic RST_STEP_UP = 1'b1;
	localparam logic RST_SEL_DD = 1'b1;

	typedef enum logic [1:0] {BM_8080, BM_6800, BM_SERIAL} cdd_bus_mode_t;

	typedef struct packed {
		logic [1:0] mode;
		logic cs_n;
		logic rs;
		logic rd;
		logic wr;
		logic [7:0] db;
	} cdd_pins_t;

	typedef struct packed {
		logic screen_on;
		logic pointer_mark_shown;
		logic flashing_on;
		logic step_up;
		logic window_glide_on_entry;
		logic bus_width_8;
		logic two_row;
		logic glyph_height;
		logic [1:0] font_table_select;
		logic graphic_select;
		logic dcdc_enable;
	} cdd_cfg_t;

endpackage

/* dv/cdd_decoder_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module cdd_decoder_checker #(
	parameter int unsigned CLEAR_CYC = cdd_pkg::CLEAR_CYC_DFLT
) (
	input wire logic core_clk_i, // Clock
	input wire logic rst_b_i, // Reset, active low
	input wire cdd_pkg::cdd_bus_mode_t bus_mode_i, // Bus style
	input wire logic chip_select_n_i, // Chip select
	input wire logic register_select_i, // Latch select
	input wire logic strobe_read_i, // Read strobe
	input wire logic rw_strobe_write_i, // Write strobe
	input wire logic [7:0] db_o, // Data out
	input wire logic [7:0] db_oe_o, // Drive enables
	input wire logic busy_indicator_o, // Busy
	input wire logic [6:0] cursor_pointer_o, // Pointer
	input wire logic [6:0] display_offset_o, // Shift amount
	input wire logic sel_display_ram_o, // RAM target
	input wire cdd_pkg::cdd_cfg_t cfg_o // Settings
);
	import cdd_pkg::*;
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	logic [23:0] busy_cnt_r, busy_cnt_nxt;
	logic [7:0] quiet_r, quiet_nxt;
	logic m80;
	assign m80 = (bus_mode_i == BM_8080);
	always_comb begin
		busy_cnt_nxt = busy_indicator_o ? busy_cnt_r + 24'h000001 : 24'h000000;
		quiet_nxt = quiet_r;
		if (!(strobe_read_i && rw_strobe_write_i)) begin
			quiet_nxt = 8'h00;
		end else if (quiet_r != 8'hFF) begin
			quiet_nxt = quiet_r + 8'h01;
		end
	end
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			busy_cnt_r <= 24'h000000;
			quiet_r <= 8'hFF;
		end else begin
			busy_cnt_r <= busy_cnt_nxt;
			quiet_r <= quiet_nxt;
		end
	end
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	sequence s_stat_rd;
		m80 && cfg_o.bus_width_8 && !chip_select_n_i && !register_select_i
			&& !busy_indicator_o && $fell(strobe_read_i)
			##1 (!strobe_read_i && !busy_indicator_o)[*7];
	endsequence
	sequence s_rd_held;
		(m80 && cfg_o.bus_width_8 && !chip_select_n_i && !strobe_read_i)[*8];
	endsequence
	property p_stat_rd;
		s_stat_rd |-> db_o == {1'b0, cursor_pointer_o};
	endproperty
	a_stat_rd: assert property (p_stat_rd) else $error("status byte");
	property p_rd_drive;
		s_rd_held |-> db_oe_o == 8'hFF;
	endproperty
	a_rd_drive: assert property (p_rd_drive) else $error("no drive");
	property p_no_drive;
		(m80 && strobe_read_i)[*8] |-> db_oe_o == 8'h00;
	endproperty
	a_no_drive: assert property (p_no_drive) else $error("drive");
	property p_cs_off;
		chip_select_n_i[*8] |-> db_oe_o == 8'h00;
	endproperty
	a_cs_off: assert property (p_cs_off) else $error("drive off");
	property p_busy_min;
		$rose(busy_indicator_o) |-> busy_indicator_o[*3];
	endproperty
	a_busy_min: assert property (p_busy_min) else $error("busy short");
	property p_busy_max;
		busy_cnt_r <= CLEAR_CYC + 8;
	endproperty
	a_busy_max: assert property (p_busy_max) else $error("busy long");
	property p_busy_cause;
		m80 && $rose(busy_indicator_o) |-> quiet_r < 8'h0A;
	endproperty
	a_busy_cause: assert property (p_busy_cause) else $error("busy cause");
	property p_ptr_quiet;
		(!busy_indicator_o)[*4] |->
			$stable(cursor_pointer_o) && $stable(sel_display_ram_o);
	endproperty
	a_ptr_quiet: assert property (p_ptr_quiet) else $error("ptr");
	property p_cfg_quiet;
		(!busy_indicator_o)[*4] |->
			$stable(cfg_o) && $stable(display_offset_o);
	endproperty
	a_cfg_quiet: assert property (p_cfg_quiet) else $error("cfg");
endmodule // cdd_decoder_checker
bind cdd_decoder cdd_decoder_checker #(.CLEAR_CYC(CLEAR_CYC)) chk_u (
	.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .bus_mode_i(bus_mode_i),
	.chip_select_n_i(chip_select_n_i), .register_select_i(register_select_i),
	.strobe_read_i(strobe_read_i), .rw_strobe_write_i(rw_strobe_write_i),
	.db_o(db_o), .db_oe_o(db_oe_o), .busy_indicator_o(busy_indicator_o),
	.cursor_pointer_o(cursor_pointer_o), .display_offset_o(display_offset_o),
	.sel_display_ram_o(sel_display_ram_o), .cfg_o(cfg_o)
);
`default_nettype wire

/* dv/cdd_host.sv */
`timescale 1ns/1ps
`default_nettype none
module cdd_host (
	input wire logic core_clk_i, // Clock
	input wire logic [7:0] dev_db_i, // Device data out
	input wire logic [7:0] dev_oe_i, // Device drive enables
	input wire cdd_pkg::cdd_bus_mode_t mode_i, // Bus style
	output logic cs_n_o, // Chip select
	output logic rs_o, // Latch select
	output logic rd_n_o, // Read strobe
	output logic wr_n_o, // Write strobe
	output logic [7:0] pin_o // Wire level
);
	import cdd_pkg::*;
	logic [7:0] hv_r;
	initial begin
		cs_n_o = 1'b1;
		rs_o = 1'b0;
		rd_n_o = 1'b1;
		wr_n_o = 1'b1;
		hv_r = 8'h00;
	end
	// Released lines show the inverse, never a stale copy
	assign pin_o = (dev_oe_i & dev_db_i) | (~dev_oe_i & hv_r);
	// Parallel cycle: setup, 256 ns pulse, hold, over 500 ns in all
	task automatic xfer(input logic rs, input logic rd, input logic [7:0] d,
		output logic [7:0] q);
		logic [9:0] f;
		f = {rs, rd, d};
		q = 8'h00;
		@(posedge core_clk_i);
		cs_n_o <= 1'b0;
		rs_o <= rs;
		if (mode_i == BM_SERIAL) begin
			// SCL idles low; SDO is taken just before rises 3 to 10
			for (int i = 9; i >= 0; i--) begin
				hv_r <= {f[i], hv_r[6], 1'b0, hv_r[4:0]};
				repeat (6) @(posedge core_clk_i);
				if (i < 8) q[i] = pin_o[6];
				hv_r <= {hv_r[7:6], 1'b1, hv_r[4:0]};
				repeat (6) @(posedge core_clk_i);
			end
		end else begin
			if (rd) hv_r <= ~hv_r;
			else hv_r <= d;
			// 6800: E idles low, R/W settles before E rises
			rd_n_o <= (mode_i != BM_6800);
			wr_n_o <= (mode_i == BM_6800) ? rd : 1'b1;
			repeat (4) @(posedge core_clk_i);
			if (mode_i == BM_6800) rd_n_o <= 1'b1;
			else if (rd) rd_n_o <= 1'b0;
			else wr_n_o <= 1'b0;
			repeat (32) @(posedge core_clk_i);
			q = pin_o;
			rd_n_o <= (mode_i != BM_6800);
			if (mode_i != BM_6800) wr_n_o <= 1'b1;
		end
		repeat (4) @(posedge core_clk_i);
		hv_r <= ~hv_r;
		cs_n_o <= 1'b1;
		repeat (30) @(posedge core_clk_i);
	endtask
endmodule // cdd_host
`default_nettype wire

/* dv/char_display_instruction_decoder_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin num_errors++; \
	$display("wrong value at %0t: got %h want %h", $time, a, e); end end
module char_display_instruction_decoder_tb;
	import cdd_pkg::*;
	typedef struct packed {logic [7:0] cmd; cdd_cfg_t cfg;} cdd_row_t;
	logic core_clk_i = 1'b0, rst_b_i = 1'b0;
	logic cs_n, rs, rd_n, wr_n, busy, sel;
	logic [7:0] pins, db_o, db_oe, dv, gv, q;
	logic [6:0] ptr, offs, dv_addr = 7'h05;
	logic [5:0] gv_addr = 6'h0A;
	cdd_cfg_t cfg;
	cdd_bus_mode_t mode = BM_8080;
	int num_errors = 0, n_tests = 0;
	cdd_row_t rows [9] = '{'{8'h0F, 12'hF40}, '{8'h0E, 12'hD40},
		'{8'h3B, 12'hD6C}, '{8'h34, 12'hD50}, '{8'h1F, 12'hD53},
		'{8'h13, 12'hD50}, '{8'h04, 12'hC50}, '{8'h07, 12'hDD0},
		'{8'h06, 12'hD50}};
	always #4 core_clk_i = ~core_clk_i;
	cdd_decoder #(.CLEAR_CYC(200), .CMD_CYC(4)) dut_u (
		.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .bus_mode_i(mode),
		.chip_select_n_i(cs_n), .register_select_i(rs), .strobe_read_i(rd_n),
		.rw_strobe_write_i(wr_n), .db_i(pins), .db_o(db_o), .db_oe_o(db_oe),
		.busy_indicator_o(busy), .cursor_pointer_o(ptr),
		.display_offset_o(offs), .sel_display_ram_o(sel), .cfg_o(cfg),
		.display_view_addr_i(dv_addr), .display_view_o(dv),
		.glyph_view_addr_i(gv_addr), .glyph_view_o(gv));
	cdd_host host_u (.core_clk_i(core_clk_i), .dev_db_i(db_o), .mode_i(mode),
		.dev_oe_i(db_oe), .cs_n_o(cs_n), .rs_o(rs), .rd_n_o(rd_n),
		.wr_n_o(wr_n), .pin_o(pins));
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic wr(input logic r, input logic [7:0] d);
		logic [7:0] x;
		host_u.xfer(r, 1'b0, d, x);
	endtask
	task automatic rdb(input logic r, output logic [7:0] d);
		host_u.xfer(r, 1'b1, 8'h00, d);
	endtask
	// Poll the status byte until idle
	task automatic wait_idle();
		logic [7:0] s;
		for (int i = 0; i < 20; i++) begin
			rdb(1'b0, s);
			if (s[7] === 1'b0) return;
		end
		num_errors++;
		$display("wrong value at %0t: busy never ends", $time);
		wrap_up();
	endtask
	task automatic cmd(input logic [7:0] d);
		wr(1'b0, d);
		wait_idle();
	endtask
	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		repeat (12) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
		@(negedge core_clk_i);
		`CHK({busy, ptr, offs, sel}, {1'b0, 7'h00, 7'h00, 1'b1})
		`CHK(cfg, 12'h140)
		$display("reset test done");
		for (int i = 0; i < 9; i++) begin
			cmd(rows[i].cmd);
			`CHK(cfg, rows[i].cfg)
		end
		$display("command table done");
		cmd(8'h85);
		`CHK({ptr, sel}, {7'h05, 1'b1})
		wr(1'b1, 8'h41);
		wait_idle();
		`CHK(ptr, 7'h06)
		`CHK(dv, 8'h41)
		rdb(1'b0, q);
		`CHK(q, 8'h06)
		cmd(8'h85);
		rdb(1'b1, q);
		`CHK(q, 8'h41)
		wait_idle();
		`CHK(ptr, 7'h06)
		cmd(8'h04);
		wr(1'b1, 8'h42);
		wait_idle();
		`CHK(ptr, 7'h05)
		$display("display ram test done");
		cmd(8'h4A);
		`CHK({ptr, sel}, {7'h0A, 1'b0})
		wr(1'b1, 8'h1F);
		wait_idle();
		`CHK(gv, 8'h1F)
		`CHK(ptr, 7'h09)
		$display("glyph ram test done");
		cmd(8'h85);
		cmd(8'h14);
		`CHK(ptr, 7'h06)
		cmd(8'h10);
		`CHK(ptr, 7'h05)
		cmd(8'h1C);
		`CHK({ptr, offs}, {7'h05, 7'h01})
		cmd(8'h02);
		`CHK({ptr, offs, dv}, {7'h00, 7'h00, 8'h41})
		cmd(8'h07);
		cmd(8'h80);
		wr(1'b1, 8'h43);
		wait_idle();
		`CHK({ptr, offs}, {7'h01, 7'h7F})
		$display("shift test done");
		// Deliberately ignores polling to hit the busy window
		wr(1'b0, 8'h01);
		wr(1'b0, 8'h08);
		rdb(1'b0, q);
		`CHK(q[7], 1'b1)
		wait_idle();
		`CHK(cfg, 12'hDD0)
		`CHK({ptr, offs, dv}, {7'h00, 7'h00, 8'h20})
		$display("clear test done");
		wr(1'b0, 8'h2C);
		`CHK(cfg, 12'hDB0)
		wr(1'b0, 8'h30);
		`CHK(cfg, 12'hDB0)
		wr(1'b0, 8'h80);
		`CHK(cfg, 12'hDE0)
		$display("nibble test done");
		mode <= BM_6800;
		repeat (4) @(posedge core_clk_i);
		cmd(8'h09);
		`CHK(cfg, 12'h3E0)
		cmd(8'h83);
		wr(1'b1, 8'h5A);
		wait_idle();
		cmd(8'h83);
		rdb(1'b1, q);
		`CHK(q, 8'h5A)
		$display("6800 test done");
		mode <= BM_SERIAL;
		repeat (4) @(posedge core_clk_i);
		cmd(8'h85);
		rdb(1'b0, q);
		`CHK(q, 8'h05)
		rdb(1'b1, q);
		`CHK(q, 8'h20)
		wait_idle();
		`CHK(ptr, 7'h06)
		$display("serial test done");
		rst_b_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		`CHK({busy, ptr, offs, sel, db_oe}, {1'b0, 7'h00, 7'h00, 1'b1, 8'h00})
		`CHK(cfg, 12'h140)
		rst_b_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		`CHK(cfg, 12'h140)
		$display("mid-run reset test done");
		wrap_up();
	end
endmodule // char_display_instruction_decoder_tb
`default_nettype wire
